// ===== rtl/pti_target.sv
// Target end: decode, claim, wait states, parity, interrupt
`timescale 1ns/1ps
`include "pti_cfg.svh"

module pti_target (
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       sys_rst_i,
	// Bus side
	pti_bus_if.target       bus,
	// User side
	input  wire logic [6:0] irq_event_i,
	input  wire logic       stop_req_i,
	output logic            perr_o
);
	pti_pkg::pti_tstate_type state;
	logic [31:0] addr_q;
	logic        rd_q;
	logic        cfg_q;
	logic        ioen;
	logic [26:0] io_base;
	logic [7:0]  cause;
	logic [7:0]  mask;
	logic [31:0] mem [8];
	logic        chk_pend;
	logic        exp_par;

	////////////////////////////////////////////////////////////////////////
	// Address phase decode
	wire logic [3:0] cmd      = bus.cbe_n;
	wire logic       cmd_cfg  = (cmd == pti_pkg::PTI_CMD_CFG_RD) ||
	                            (cmd == pti_pkg::PTI_CMD_CFG_WR);
	wire logic       cmd_io   = (cmd == pti_pkg::PTI_CMD_IO_RD) ||
	                            (cmd == pti_pkg::PTI_CMD_IO_WR);
	wire logic       cmd_rd   = (cmd == pti_pkg::PTI_CMD_IO_RD) ||
	                            (cmd == pti_pkg::PTI_CMD_CFG_RD);
	wire logic       cfg_hit  = cmd_cfg && bus.idsel &&
	                            (bus.ad[1:0] == `PTI_CFG_TYPE0);
	wire logic       io_hit   = cmd_io && ioen && (bus.ad[31:5] == io_base);
	wire logic       addr_ph  = (state == pti_pkg::PTI_T_IDLE) && !bus.frame_n;
	wire logic       claim    = addr_ph && (cfg_hit || io_hit);
	wire logic       complete = (state == pti_pkg::PTI_T_DATA) &&
	                            !bus.irdy_n && !bus.trdy_n;
	wire logic       last     = complete && bus.frame_n;
	wire logic       gone     = bus.frame_n && bus.irdy_n &&
	                            (state != pti_pkg::PTI_T_IDLE);

	////////////////////////////////////////////////////////////////////////
	// Parity: checker on the received lanes, generator on read data
	logic par_rx;
	logic par_tx;
	pti_parity u_par_rx (
		.data_i (bus.ad),
		.cbe_i  (bus.cbe_n),
		.par_o  (par_rx)
	);
	pti_parity u_par_tx (
		.data_i (bus.t_ad),
		.cbe_i  (bus.cbe_n),
		.par_o  (par_tx)
	);
	// Master's PAR arrives one clock after the sampled lanes
	wire logic perr_evt = chk_pend && (bus.par != exp_par);

	////////////////////////////////////////////////////////////////////////
	// Read data selection
	wire logic [5:0]  cfg_idx = addr_q[7:2];
	wire logic [2:0]  io_idx  = addr_q[4:2];
	wire logic [31:0] cfg_rd  =
		(cfg_idx == `PTI_CFG_IDX_ID)  ? `PTI_ID_WORD :
		(cfg_idx == `PTI_CFG_IDX_CMD) ? {31'h0000_0000, ioen} :
		(cfg_idx == `PTI_CFG_IDX_BAR) ? {io_base, `PTI_BAR_SPACE} : 32'h0000_0000;
	wire logic [31:0] io_rd   =
		(io_idx == `PTI_IO_IDX_CAUSE) ? {24'h00_0000, cause} :
		(io_idx == `PTI_IO_IDX_MASK)  ? {24'h00_0000, mask} : mem[io_idx];
	wire logic [31:0] rd_word = cfg_q ? cfg_rd : io_rd;

	////////////////////////////////////////////////////////////////////////
	// Write decode with byte lanes
	function automatic logic [31:0] pti_merge(input logic [31:0] old,
	                                          input logic [31:0] nw,
	                                          input logic [3:0]  be_n);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (!be_n[i]) begin
				res[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return res;
	endfunction : pti_merge

	wire logic        wr_cmt    = complete && !rd_q;
	wire logic        wr_cmd    = wr_cmt && cfg_q && (cfg_idx == `PTI_CFG_IDX_CMD);
	wire logic        wr_bar    = wr_cmt && cfg_q && (cfg_idx == `PTI_CFG_IDX_BAR);
	wire logic        wr_cause  = wr_cmt && !cfg_q && (io_idx == `PTI_IO_IDX_CAUSE);
	wire logic        wr_mask   = wr_cmt && !cfg_q && (io_idx == `PTI_IO_IDX_MASK);
	wire logic        wr_mem    = wr_cmt && !cfg_q && !wr_cause && !wr_mask;
	wire logic [31:0] bar_new   = pti_merge({io_base, 5'h00}, bus.ad, bus.cbe_n);
	wire logic [31:0] mask_new  = pti_merge({24'h00_0000, mask}, bus.ad, bus.cbe_n);
	wire logic [31:0] cmd_new   = pti_merge({31'h0000_0000, ioen}, bus.ad, bus.cbe_n);
	wire logic [31:0] clr_word  = pti_merge(32'h0000_0000, bus.ad, bus.cbe_n);
	wire logic [7:0]  cause_clr = wr_cause ? clr_word[7:0] : 8'h00;
	wire logic [7:0]  cause_set = {perr_evt, irq_event_i};
	// Set after clear so an event in the clearing cycle survives
	wire logic [7:0]  next_cause = (cause & ~cause_clr) | cause_set;

	always_ff @(posedge clk_i) begin
		if (wr_mem) begin
			mem[io_idx] <= pti_merge(mem[io_idx], bus.ad, bus.cbe_n);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Transaction sequencer
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state        <= pti_pkg::PTI_T_IDLE;
			addr_q       <= 32'h0000_0000;
			rd_q         <= 1'b0;
			cfg_q        <= 1'b0;
			bus.devsel_n <= 1'b1;
			bus.trdy_n   <= 1'b1;
			bus.stop_n   <= 1'b1;
			bus.t_ad     <= 32'h0000_0000;
			bus.t_ad_oe  <= 1'b0;
		end else begin
			case (state)
				pti_pkg::PTI_T_IDLE: begin
					if (claim) begin
						addr_q       <= bus.ad;
						rd_q         <= cmd_rd;
						cfg_q        <= cmd_cfg;
						bus.devsel_n <= 1'b0;
						state        <= pti_pkg::PTI_T_WAIT;
					end
				end
				pti_pkg::PTI_T_WAIT: begin
					if (gone) begin
						state <= pti_pkg::PTI_T_TURN;
					end else begin
						// One wait state lets the read word settle
						bus.t_ad    <= rd_word;
						bus.t_ad_oe <= rd_q;
						bus.trdy_n  <= 1'b0;
						if (stop_req_i) begin
							bus.stop_n <= 1'b0;
						end
						state <= pti_pkg::PTI_T_DATA;
					end
				end
				pti_pkg::PTI_T_DATA: begin
					if (last || gone) begin
						bus.trdy_n <= 1'b1;
						state      <= pti_pkg::PTI_T_TURN;
					end else if (complete) begin
						addr_q     <= addr_q + 32'h0000_0004;
						bus.trdy_n <= 1'b1;
						state      <= pti_pkg::PTI_T_WAIT;
					end
				end
				pti_pkg::PTI_T_TURN: begin
					bus.devsel_n <= 1'b1;
					bus.stop_n   <= 1'b1;
					bus.t_ad_oe  <= 1'b0;
					state        <= pti_pkg::PTI_T_IDLE;
				end
				default: begin
					state <= pti_pkg::PTI_T_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Parity, registers and interrupt
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			bus.t_par    <= 1'b0;
			bus.t_par_oe <= 1'b0;
			chk_pend     <= 1'b0;
			exp_par      <= 1'b0;
			perr_o       <= 1'b0;
			ioen         <= `PTI_IOEN_RST;
			io_base      <= `PTI_BAR_RST;
			cause        <= `PTI_CAUSE_RST;
			mask         <= `PTI_MASK_RST;
			bus.inta_oe  <= 1'b0;
		end else begin
			// Follows the read data one clock late, so it also stays one
			// clock past the last phase
			bus.t_par    <= par_tx;
			bus.t_par_oe <= bus.t_ad_oe;
			chk_pend     <= claim || wr_cmt;
			exp_par      <= par_rx;
			perr_o       <= perr_evt;
			cause        <= next_cause;
			bus.inta_oe  <= |(next_cause & mask);
			if (wr_cmd) begin
				ioen <= cmd_new[0];
			end
			if (wr_bar) begin
				io_base <= bar_new[31:5];
			end
			if (wr_mask) begin
				mask <= mask_new[7:0];
			end
		end
	end

endmodule : pti_target

// ===== rtl/pti_cfg.svh
// Shared constants of the target interface and its bus master
`ifndef PTI_CFG_SVH
`define PTI_CFG_SVH

// Idle level of the shared wires (pull-ups)
`define PTI_AD_PULL      32'hFFFF_FFFF
`define PTI_CBE_IDLE     4'hF
// Read-only identity word of configuration space (value arbitrary)
`define PTI_ID_WORD      32'h5A5A_0001
// Configuration space word indices and the type 0 address code
`define PTI_CFG_IDX_ID   6'h00
`define PTI_CFG_IDX_CMD  6'h01
`define PTI_CFG_IDX_BAR  6'h04
`define PTI_CFG_TYPE0    2'h0
// I/O space word indices inside the 32-byte window
`define PTI_IO_IDX_CAUSE 3'h0
`define PTI_IO_IDX_MASK  3'h1
// Reset values and the fixed space bits of the BAR word
`define PTI_BAR_RST      27'h000_0000
`define PTI_CAUSE_RST    8'h00
`define PTI_MASK_RST     8'h00
`define PTI_IOEN_RST     1'h0
`define PTI_BAR_SPACE    5'h01
// Master gives up when no claim arrives within one more than this many data-phase clocks
`define PTI_ABORT_CYC    3'h5

`endif

// ===== rtl/pti_pkg.sv
// Types shared by the target and the master end
package pti_pkg;

	typedef enum logic [3:0] {
		PTI_CMD_IO_RD  = 4'h2,
		PTI_CMD_IO_WR  = 4'h3,
		PTI_CMD_CFG_RD = 4'hA,
		PTI_CMD_CFG_WR = 4'hB
	} pti_cmd_type;

	typedef enum logic [1:0] {
		PTI_T_IDLE = 2'h0,
		PTI_T_WAIT = 2'h1,
		PTI_T_DATA = 2'h3,
		PTI_T_TURN = 2'h2
	} pti_tstate_type;

	typedef enum logic [1:0] {
		PTI_M_IDLE = 2'h0,
		PTI_M_ADDR = 2'h1,
		PTI_M_DATA = 2'h3,
		PTI_M_END  = 2'h2
	} pti_mstate_type;

endpackage : pti_pkg

// ===== rtl/pti_bus_if.sv
// Bus wires between target and master, with wire resolution
`timescale 1ns/1ps
`include "pti_cfg.svh"

interface pti_bus_if;
	logic [31:0] m_ad;
	logic        m_ad_oe;
	logic [31:0] t_ad;
	logic        t_ad_oe;
	logic        m_par;
	logic        m_par_oe;
	logic        t_par;
	logic        t_par_oe;
	logic [3:0]  cbe_n;
	logic        frame_n;
	logic        irdy_n;
	logic        idsel;
	logic        trdy_n;
	logic        stop_n;
	logic        devsel_n;
	logic        inta_oe;
	wire  [31:0] ad;
	wire         par;
	wire         inta_n;

	// Undriven wires read as the pull-up level
	assign ad     = t_ad_oe ? t_ad : (m_ad_oe ? m_ad : `PTI_AD_PULL);
	assign par    = t_par_oe ? t_par : (m_par_oe ? m_par : 1'b1);
	assign inta_n = ~inta_oe;

	modport target (
		input  ad, par, cbe_n, frame_n, irdy_n, idsel,
		output t_ad, t_ad_oe, t_par, t_par_oe, trdy_n, stop_n, devsel_n, inta_oe
	);
	modport master (
		input  ad, par, trdy_n, stop_n, devsel_n, inta_n,
		output m_ad, m_ad_oe, m_par, m_par_oe, cbe_n, frame_n, irdy_n, idsel
	);
endinterface : pti_bus_if

// ===== rtl/pti_parity.sv
// Even parity over the 32 data bits and the four command/enable bits
`timescale 1ns/1ps

module pti_parity (
	// Lanes covered
	input  wire logic [31:0] data_i,
	input  wire logic [3:0]  cbe_i,
	// Bit that makes the count of ones even
	output logic             par_o
);
	assign par_o = ^{data_i, cbe_i};
endmodule : pti_parity

// ===== rtl/pti_master.sv
// Master end: one single-phase access per request
`timescale 1ns/1ps
`include "pti_cfg.svh"

module pti_master (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        sys_rst_i,
	// Bus side
	pti_bus_if.master        bus,
	// Request
	input  wire logic        req_i,
	input  wire logic [3:0]  req_cmd_i,
	input  wire logic [31:0] req_addr_i,
	input  wire logic [31:0] req_wdata_i,
	input  wire logic [3:0]  req_be_n_i,
	input  wire logic        req_idsel_i,
	// Answer
	output logic             busy_o,
	output logic             done_o,
	output logic [31:0]      rdata_o,
	output logic             abort_o,
	output logic             stopped_o,
	output logic             perr_o,
	output logic             irq_o
);
	pti_pkg::pti_mstate_type state;
	logic        rd_q;
	logic        rd_chk;
	logic [31:0] wdata_q;
	logic [3:0]  be_q;
	logic [2:0]  cnt;

	wire logic is_rd = (req_cmd_i == pti_pkg::PTI_CMD_IO_RD) ||
	                   (req_cmd_i == pti_pkg::PTI_CMD_CFG_RD);
	wire logic done  = !bus.trdy_n && !bus.irdy_n;

	logic par_out;
	logic par_in;
	pti_parity u_par_out (
		.data_i (bus.m_ad),
		.cbe_i  (bus.cbe_n),
		.par_o  (par_out)
	);
	pti_parity u_par_in (
		.data_i (rdata_o),
		.cbe_i  (be_q),
		.par_o  (par_in)
	);

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			state        <= pti_pkg::PTI_M_IDLE;
			bus.m_ad     <= 32'h0000_0000;
			bus.m_ad_oe  <= 1'b0;
			bus.m_par    <= 1'b0;
			bus.m_par_oe <= 1'b0;
			bus.cbe_n    <= `PTI_CBE_IDLE;
			bus.frame_n  <= 1'b1;
			bus.irdy_n   <= 1'b1;
			bus.idsel    <= 1'b0;
			rd_q         <= 1'b0;
			rd_chk       <= 1'b0;
			wdata_q      <= 32'h0000_0000;
			be_q         <= `PTI_CBE_IDLE;
			cnt          <= 3'h0;
			busy_o       <= 1'b0;
			done_o       <= 1'b0;
			rdata_o      <= 32'h0000_0000;
			abort_o      <= 1'b0;
			stopped_o    <= 1'b0;
			perr_o       <= 1'b0;
			irq_o        <= 1'b0;
		end else begin
			// Address and write parity trail the driven lanes by one clock
			bus.m_par    <= par_out;
			bus.m_par_oe <= bus.m_ad_oe;
			irq_o        <= !bus.inta_n;
			done_o       <= 1'b0;
			case (state)
				pti_pkg::PTI_M_IDLE: begin
					if (req_i) begin
						bus.frame_n <= 1'b0;
						bus.m_ad    <= req_addr_i;
						bus.m_ad_oe <= 1'b1;
						bus.cbe_n   <= req_cmd_i;
						bus.idsel   <= req_idsel_i;
						rd_q        <= is_rd;
						wdata_q     <= req_wdata_i;
						be_q        <= req_be_n_i;
						busy_o      <= 1'b1;
						abort_o     <= 1'b0;
						stopped_o   <= 1'b0;
						perr_o      <= 1'b0;
						state       <= pti_pkg::PTI_M_ADDR;
					end
				end
				pti_pkg::PTI_M_ADDR: begin
					bus.frame_n <= 1'b1;
					bus.irdy_n  <= 1'b0;
					bus.cbe_n   <= be_q;
					bus.idsel   <= 1'b0;
					bus.m_ad    <= wdata_q;
					bus.m_ad_oe <= !rd_q;
					cnt         <= 3'h0;
					state       <= pti_pkg::PTI_M_DATA;
				end
				pti_pkg::PTI_M_DATA: begin
					cnt <= cnt + 3'h1;
					if (done || !bus.stop_n ||
					    (bus.devsel_n && (cnt == `PTI_ABORT_CYC))) begin
						bus.irdy_n  <= 1'b1;
						bus.m_ad_oe <= 1'b0;
						rdata_o     <= bus.ad;
						rd_chk      <= done && rd_q;
						// Reported with or without data, so a disconnect shows too
						stopped_o   <= !bus.stop_n;
						abort_o     <= !done && bus.stop_n;
						state       <= pti_pkg::PTI_M_END;
					end
				end
				pti_pkg::PTI_M_END: begin
					// Read parity comes from the target one clock after completion
					perr_o    <= rd_chk && (bus.par != par_in);
					rd_chk    <= 1'b0;
					bus.cbe_n <= `PTI_CBE_IDLE;
					busy_o    <= 1'b0;
					done_o    <= 1'b1;
					state     <= pti_pkg::PTI_M_IDLE;
				end
				default: begin
					state <= pti_pkg::PTI_M_IDLE;
				end
			endcase
		end
	end

endmodule : pti_master

// ===== tb/pti_chk.sv
// Concurrent checks on the wires between target and master
`timescale 1ns/1ps

module pti_chk (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        sys_rst_i,
	// Bus wires
	input  wire logic [31:0] ad,
	input  wire logic        par,
	input  wire logic [3:0]  cbe_n,
	input  wire logic        frame_n,
	input  wire logic        irdy_n,
	input  wire logic        idsel,
	input  wire logic        trdy_n,
	input  wire logic        stop_n,
	input  wire logic        devsel_n,
	input  wire logic        t_ad_oe,
	input  wire logic        t_par_oe
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	////////////////////////////////////////////////////////////////////////////////
	property p_adr_par;
		$fell(frame_n) |=> par == ^{$past(ad), $past(cbe_n)};
	endproperty
	a_adr_par: assert property (p_adr_par)
		else $error("address parity wrong");
	property p_wr_par;
		(!irdy_n && !trdy_n && !t_ad_oe) |=> par == ^{$past(ad), $past(cbe_n)};
	endproperty
	a_wr_par: assert property (p_wr_par)
		else $error("write data parity wrong");
	property p_wr_hold;
		(!irdy_n && !trdy_n && !t_ad_oe) |=> $stable(par);
	endproperty
	a_wr_hold: assert property (p_wr_hold)
		else $error("write parity not held");
	// Read parity lags the data by one clock, so it is judged one edge later
	property p_rd_par;
		(!irdy_n && !trdy_n && t_ad_oe) |=> t_par_oe && par == ^{$past(ad), $past(cbe_n)};
	endproperty
	a_rd_par: assert property (p_rd_par)
		else $error("read data parity wrong");
	property p_par_own;
		t_par_oe |-> $past(t_ad_oe);
	endproperty
	a_par_own: assert property (p_par_own)
		else $error("parity driven outside a read");

	////////////////////////////////////////////////////////////////////////////////
	property p_cfg_hit;
		($fell(frame_n) && idsel && cbe_n[3:1] == 3'h5 && ad[1:0] == 2'h0) |=> !devsel_n;
	endproperty
	a_cfg_hit: assert property (p_cfg_hit)
		else $error("configuration access not claimed");
	property p_cfg_miss;
		($fell(frame_n) && !idsel && cbe_n[3:1] == 3'h5) |=> devsel_n [*3];
	endproperty
	a_cfg_miss: assert property (p_cfg_miss)
		else $error("configuration claimed without select");
	property p_wait;
		($fell(frame_n) ##1 !devsel_n) |=> !trdy_n;
	endproperty
	a_wait: assert property (p_wait)
		else $error("ready not two clocks after address");
	property p_end;
		(!irdy_n && !trdy_n && frame_n) |=> (irdy_n && trdy_n) ##1 (devsel_n && stop_n);
	endproperty
	a_end: assert property (p_end)
		else $error("transaction not ended after last phase");
	property p_stop;
		!stop_n |-> !devsel_n;
	endproperty
	a_stop: assert property (p_stop)
		else $error("stop outside a claimed access");
endmodule : pti_chk

// ===== tb/testbench.sv
// Bench joining target and master ends over the shared bus
`timescale 1ns/1ps
`include "pti_cfg.svh"

module testbench;
	typedef struct packed {
		logic [3:0]  cmd;
		logic [31:0] addr;
		logic [31:0] wd;
		logic [3:0]  be;
		logic        ids;
		logic [31:0] exp;
		logic        ab;
	} pti_row_type;
	localparam logic [3:0]  c_ird   = pti_pkg::PTI_CMD_IO_RD;
	localparam logic [3:0]  c_iwr   = pti_pkg::PTI_CMD_IO_WR;
	localparam logic [3:0]  c_crd   = pti_pkg::PTI_CMD_CFG_RD;
	localparam logic [3:0]  c_cwr   = pti_pkg::PTI_CMD_CFG_WR;
	localparam logic [31:0] io_base = 32'h0000_1000;
	logic        clk_i;
	logic        sys_rst_i;
	logic [6:0]  irq_event_i;
	logic        stop_req_i;
	logic        perr_t;
	logic        perr_seen   = 1'b0;
	logic        req_i;
	logic [3:0]  req_cmd_i;
	logic [31:0] req_addr_i;
	logic [31:0] req_wdata_i;
	logic [3:0]  req_be_n_i;
	logic        req_idsel_i;
	logic        busy_o, done_o, abort_o, stopped_o, perr_o, irq_o;
	logic [31:0] rdata_o;
	int          error_cnt   = 0;
	int          checks_done = 0;
	int          cycles      = 0;
	pti_row_type rows [10];

	pti_bus_if bus_if_i ();
	pti_target pti_target_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .bus(bus_if_i),
		.irq_event_i(irq_event_i), .stop_req_i(stop_req_i), .perr_o(perr_t));
	pti_master pti_master_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .bus(bus_if_i),
		.req_i(req_i), .req_cmd_i(req_cmd_i), .req_addr_i(req_addr_i),
		.req_wdata_i(req_wdata_i), .req_be_n_i(req_be_n_i), .req_idsel_i(req_idsel_i),
		.busy_o(busy_o), .done_o(done_o), .rdata_o(rdata_o), .abort_o(abort_o),
		.stopped_o(stopped_o), .perr_o(perr_o), .irq_o(irq_o));
	pti_chk pti_chk_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ad(bus_if_i.ad),
		.par(bus_if_i.par), .cbe_n(bus_if_i.cbe_n), .frame_n(bus_if_i.frame_n),
		.irdy_n(bus_if_i.irdy_n), .idsel(bus_if_i.idsel), .trdy_n(bus_if_i.trdy_n),
		.stop_n(bus_if_i.stop_n), .devsel_n(bus_if_i.devsel_n),
		.t_ad_oe(bus_if_i.t_ad_oe), .t_par_oe(bus_if_i.t_par_oe));

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : check

	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : summarize

	// Entered just after an edge; returns in the cycle where done_o shows
	task automatic access(input logic [3:0] cmd, input logic [31:0] addr,
		input logic [31:0] wd, input logic [3:0] be, input logic ids);
		int n;
		req_cmd_i = cmd;
		req_addr_i = addr;
		req_wdata_i = wd;
		req_be_n_i = be;
		req_idsel_i = ids;
		req_i = 1'b1;
		@(posedge clk_i);
		#1;
		req_i = 1'b0;
		check({31'h0, busy_o}, 32'h1);
		n = 0;
		while (done_o !== 1'b1 && n < 12) begin
			@(posedge clk_i);
			#1;
			n++;
		end
		check({30'h0, busy_o, done_o}, 32'h1);
	endtask : access

	task automatic pulse_irq(input logic [6:0] ev);
		irq_event_i = ev;
		@(posedge clk_i);
		#1;
		irq_event_i = 7'h00;
		repeat (3) @(posedge clk_i);
		#1;
	endtask : pulse_irq

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i; // below the bus range; no logic depends on the rate
	end

	// Whole run needs little more than a hundred cycles
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		// Parity error pulses are short, so they are caught here and judged at the end
		if (!sys_rst_i && perr_t !== 1'b0)
			perr_seen <= 1'b1;
		if (cycles == 2000) begin
			error_cnt++;
			summarize();
		end
	end

	initial begin
		sys_rst_i = 1'b1;
		irq_event_i = 7'h00;
		stop_req_i = 1'b0;
		req_i = 1'b0;
		req_cmd_i = 4'h0;
		req_addr_i = 32'h0;
		req_wdata_i = 32'h0;
		req_be_n_i = 4'hF;
		req_idsel_i = 1'b0;
		rows = '{
			'{c_crd, 32'h0, 32'h0, 4'h0, 1'b1, `PTI_ID_WORD, 1'b0},
			'{c_crd, 32'h0, 32'h0, 4'h0, 1'b0, 32'h0, 1'b1},
			'{c_cwr, 32'h10, io_base, 4'h0, 1'b1, 32'h0, 1'b0},
			'{c_crd, 32'h10, 32'h0, 4'h0, 1'b1, io_base | 32'h1, 1'b0},
			'{c_ird, io_base + 32'h8, 32'h0, 4'h0, 1'b0, 32'h0, 1'b1},
			'{c_cwr, 32'h4, 32'h1, 4'h0, 1'b1, 32'h0, 1'b0},
			'{c_iwr, io_base + 32'h8, 32'h1122_3344, 4'h0, 1'b0, 32'h0, 1'b0},
			'{c_iwr, io_base + 32'h8, 32'hAABB_CCDD, 4'hA, 1'b0, 32'h0, 1'b0},
			'{c_ird, io_base + 32'h8, 32'h0, 4'h0, 1'b0, 32'h11BB_33DD, 1'b0},
			'{c_ird, 32'h0000_2008, 32'h0, 4'h0, 1'b0, 32'h0, 1'b1}};
		repeat (6) @(posedge clk_i);
		#1;
		sys_rst_i = 1'b0;
		check({28'h0, perr_t, bus_if_i.devsel_n, bus_if_i.trdy_n, bus_if_i.frame_n}, 32'h7);
		foreach (rows[i]) begin
			access(rows[i].cmd, rows[i].addr, rows[i].wd, rows[i].be, rows[i].ids);
			check({30'h0, stopped_o, abort_o}, {31'h0, rows[i].ab});
			if (!rows[i].ab && !rows[i].cmd[0])
				check(rdata_o, rows[i].exp);
			check({31'h0, perr_o}, 32'h0);
			$display("row %0d done", i);
		end
		access(c_iwr, io_base + 32'h4, 32'h1, 4'h0, 1'b0);
		pulse_irq(7'h01);
		check({30'h0, bus_if_i.inta_n, irq_o}, 32'h1);
		access(c_ird, io_base, 32'h0, 4'h0, 1'b0);
		check(rdata_o, 32'h1);
		access(c_iwr, io_base, 32'hFF, 4'h0, 1'b0);
		pulse_irq(7'h02);
		check({30'h0, bus_if_i.inta_n, irq_o}, 32'h2);
		access(c_ird, io_base, 32'h0, 4'h0, 1'b0);
		check(rdata_o, 32'h2);
		$display("interrupt test done");
		stop_req_i = 1'b1;
		access(c_ird, io_base + 32'h8, 32'h0, 4'h0, 1'b0);
		stop_req_i = 1'b0;
		check({30'h0, stopped_o, abort_o}, 32'h2);
		check(rdata_o, 32'h11BB_33DD);
		$display("stop test done");
		pulse_irq(7'h01);
		check({31'h0, bus_if_i.inta_n}, 32'h0);
		sys_rst_i = 1'b1;
		// Target reset must land before the next edge
		#5;
		check({31'h0, bus_if_i.inta_n}, 32'h1);
		@(posedge clk_i);
		#1;
		sys_rst_i = 1'b0;
		access(c_ird, io_base, 32'h0, 4'h0, 1'b0);
		check({31'h0, abort_o}, 32'h1);
		check({31'h0, perr_seen}, 32'h0);
		$display("reset test done");
		summarize();
	end
endmodule : testbench
